// ### verilog/wecs_top.sv
// Wake event flags, wake enables and wake source latch with AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Wakeup frame flag bit 6, write one clears.
// - Magic packet flag bit 5, write one clears.
// - Broadcast flag bit 4, write one clears.
// - Resume end clears flags when option set.
// - Resume end clears enables 3:0 when option set.
// - Bit 3 enables station address match wake.
// - Bit 1 enables magic packet wake.
// - Wake source at 144h records wake cause.
// - No recording while entering suspend.
// - Ignore events once waking has begun.
// - Several matching conditions set several bits.
// - Source bits hold until software clears.
// - Bits 27:20 record pin wakes; reserved zero.
// - Bit 16 records IPv6 SYN wake.
// - Bit 15 records IPv4 SYN wake.
// - Bit 14 records transmit idle exit wake.
// - Idle wake bits low without EEE enable.
// - Idle wake enables permit remote wakeup.
module wecs_top #(
  parameter int PIN_COUNT = 8
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [11:0]       i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [11:0]       i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  input  wire logic              i_wake_frame_ok,
  input  wire logic              i_magic_ok,
  input  wire logic              i_bcast_ok,
  input  wire logic              i_station_addr_ok,
  input  wire logic              i_v6_syn_ok,
  input  wire logic              i_v4_syn_ok,
  input  wire logic              i_lpi_tx_exit,
  input  wire logic              i_lpi_rx_exit,
  input  wire logic [PIN_COUNT-1:0] i_pin_wake,
  input  wire logic              i_energy_efficient_enable,
  input  wire logic              i_suspend_state,
  input  wire logic              i_suspend_entering,
  input  wire logic              i_resume_done,
  output logic                   o_wake_req,
  output logic                   o_waking
);

  // The pin field is eight bits wide between two reserved fields.
  if (PIN_COUNT != 8) begin : g_bad_pins
    $error("wecs_top: PIN_COUNT must be 8");
  end

  typedef struct packed {
    wecs_pkg::wecs_state_t st;
    logic                  aw_held;
    logic [11:0]           aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [31:0]           w_mask;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [2:0]            flags;
    logic [3:0]            en;
    logic [3:0]            opts;
    logic [31:0]           src;
    logic                  wake;
  } wecs_regs_t;

  wecs_regs_t state_ff;
  wecs_regs_t nxt_state;

  logic [31:0] hit_raw;
  logic [31:0] hit_en;
  logic [31:0] src_view;
  logic [31:0] ctrl_view;
  logic [31:0] opts_view;
  logic [31:0] wr_bits;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_src;
  logic        wr_opts;
  logic        resume_end;
  logic        lpi_ok;

  // Every wake cause except the frame events, in its wake source position.
  always_comb begin
    lpi_ok  = i_energy_efficient_enable;
    hit_raw = 32'h0000_0000;
    hit_raw[wecs_pkg::SRC_PIN_LSB +: 8] = i_pin_wake;
    hit_raw[wecs_pkg::SRC_V6_SYN] = i_v6_syn_ok;
    hit_raw[wecs_pkg::SRC_V4_SYN] = i_v4_syn_ok;
    hit_raw[wecs_pkg::SRC_LPI_TX] = i_lpi_tx_exit & lpi_ok &
      state_ff.opts[wecs_pkg::OPT_LPI_TX_EN];
    hit_raw[wecs_pkg::SRC_LPI_RX] = i_lpi_rx_exit & lpi_ok &
      state_ff.opts[wecs_pkg::OPT_LPI_RX_EN];
    hit_en = hit_raw & wecs_pkg::SRC_MASK;
  end

  // Frame events count only while their own enable is set.
  logic frame_wake;
  assign frame_wake =
    (i_station_addr_ok & state_ff.en[wecs_pkg::WCS_STA_EN]) |
    (i_wake_frame_ok & state_ff.en[wecs_pkg::WCS_PAT_EN]) |
    (i_magic_ok & state_ff.en[wecs_pkg::WCS_MAGIC_EN]) |
    (i_bcast_ok & state_ff.en[wecs_pkg::WCS_BCAST_WAKE_EN]);

  // Read views; reserved bits read as zero.
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[6:4] = state_ff.flags;
    ctrl_view[3:0] = state_ff.en;
    opts_view = {28'h000_0000, state_ff.opts};
    src_view = state_ff.src & wecs_pkg::SRC_MASK;
    if (!i_energy_efficient_enable) begin
      src_view[wecs_pkg::SRC_LPI_TX] = 1'b0;
      src_view[wecs_pkg::SRC_LPI_RX] = 1'b0;
    end
  end

  // Write decode: a write happens once address and data are both held.
  assign do_write   = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;
  assign wr_ctrl    = do_write & (state_ff.aw_addr == wecs_pkg::WAKE_CTRL_ADDR);
  assign wr_src     = do_write & (state_ff.aw_addr == wecs_pkg::WAKE_SRC_ADDR);
  assign wr_opts    = do_write & (state_ff.aw_addr == wecs_pkg::WAKE_OPTS_ADDR);
  assign wr_bits    = state_ff.w_data & state_ff.w_mask;
  assign resume_end = (state_ff.st == wecs_pkg::WECS_WAKING) & i_resume_done;

  // Next state of the bus slave, the registers and the power sequence.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.wake = 1'b0;

    // Write address and data are taken independently, one of each at most.
    if (i_awvalid && o_awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = i_wdata;
      for (int b = 0; b < 4; b++) begin
        nxt_state.w_mask[8*b +: 8] = {8{i_wstrb[b]}};
      end
    end
    if (do_write) begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held  = 1'b0;
      nxt_state.bvalid  = 1'b1;
      nxt_state.bresp   = (wr_ctrl || wr_src || wr_opts) ?
                          wecs_pkg::RESP_OKAY : wecs_pkg::RESP_SLVERR;
    end
    if (state_ff.bvalid && i_bready) begin
      nxt_state.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (i_arvalid && o_arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = wecs_pkg::RESP_OKAY;
      case (i_araddr)
        wecs_pkg::WAKE_CTRL_ADDR: nxt_state.rdata = ctrl_view;
        wecs_pkg::WAKE_SRC_ADDR:  nxt_state.rdata = src_view;
        wecs_pkg::WAKE_OPTS_ADDR: nxt_state.rdata = opts_view;
        default: begin
          nxt_state.rdata = 32'h0000_0000;
          nxt_state.rresp = wecs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_ff.rvalid && i_rready) begin
      nxt_state.rvalid = 1'b0;
    end

    // Software writes: enables and options store, flags clear on one.
    if (wr_ctrl) begin
      nxt_state.en    = wr_bits[3:0] | (state_ff.en & ~state_ff.w_mask[3:0]);
      nxt_state.flags = state_ff.flags & ~wr_bits[6:4];
    end
    if (wr_opts) begin
      nxt_state.opts = wr_bits[3:0] | (state_ff.opts & ~state_ff.w_mask[3:0]);
    end
    if (wr_src) begin
      nxt_state.src = state_ff.src & ~wr_bits;
    end

    // The end of a resume may wipe flags and enables.
    if (resume_end && state_ff.opts[wecs_pkg::OPT_RES_CLR_STS]) begin
      nxt_state.flags = wecs_pkg::FLAGS_RST;
    end
    if (resume_end && state_ff.opts[wecs_pkg::OPT_RES_CLR_EN]) begin
      nxt_state.en = wecs_pkg::EN_RST;
    end

    // Receipt flags are set last, so an event beats a clear in its cycle.
    if (i_wake_frame_ok) begin
      nxt_state.flags[wecs_pkg::WCS_FRAME_FLAG - 4] = 1'b1;
    end
    if (i_magic_ok) begin
      nxt_state.flags[wecs_pkg::WCS_MAGIC_FLAG - 4] = 1'b1;
    end
    if (i_bcast_ok) begin
      nxt_state.flags[wecs_pkg::WCS_BCAST_FLAG - 4] = 1'b1;
    end

    // Power sequence: record causes only when suspended and not waking.
    case (state_ff.st)
      wecs_pkg::WECS_RUN: begin
        if (i_suspend_state && !i_suspend_entering) begin
          nxt_state.st = wecs_pkg::WECS_ARMED;
        end
      end
      wecs_pkg::WECS_ARMED: begin
        if (!i_suspend_state) begin
          nxt_state.st = wecs_pkg::WECS_RUN;
        end else if (i_suspend_entering) begin
          nxt_state.st = wecs_pkg::WECS_ARMED;
        end else if (frame_wake || (|hit_en)) begin
          nxt_state.st   = wecs_pkg::WECS_WAKING;
          nxt_state.wake = 1'b1;
          nxt_state.src  = nxt_state.src | hit_en;
        end
      end
      wecs_pkg::WECS_WAKING: begin
        if (i_resume_done) begin
          nxt_state.st = wecs_pkg::WECS_RUN;
        end
      end
      default: nxt_state.st = wecs_pkg::WECS_RUN;
    endcase
  end

  // One register stage for all state; reset loads constants only.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff         <= '0;
      state_ff.st      <= wecs_pkg::WECS_RUN;
      state_ff.flags   <= wecs_pkg::FLAGS_RST;
      state_ff.en      <= wecs_pkg::EN_RST;
      state_ff.opts    <= wecs_pkg::OPTS_RST;
      state_ff.src     <= wecs_pkg::SRC_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ready outputs are combinational, valid and data come from flip-flops.
  assign o_awready = ~state_ff.aw_held & ~state_ff.bvalid;
  assign o_wready  = ~state_ff.w_held & ~state_ff.bvalid;
  assign o_arready = ~state_ff.rvalid;
  assign o_bvalid  = state_ff.bvalid;
  assign o_bresp   = state_ff.bresp;
  assign o_rvalid  = state_ff.rvalid;
  assign o_rdata   = state_ff.rdata;
  assign o_rresp   = state_ff.rresp;
  assign o_wake_req = state_ff.wake;
  assign o_waking   = (state_ff.st == wecs_pkg::WECS_WAKING);

  // Checks of the documented behaviour.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_FRAME_FLAG: assert property (
    i_wake_frame_ok |=> state_ff.flags[2])
    else $error("Wakeup frame flag not set.");
  AST_MAGIC_CLEAR: assert property (
    wr_ctrl && wr_bits[5] && !i_magic_ok |=> !state_ff.flags[1])
    else $error("Magic flag not cleared by write of one.");
  AST_RESUME_FLAGS: assert property (
    resume_end && state_ff.opts[0] && !i_bcast_ok && !i_magic_ok
    && !i_wake_frame_ok |=> state_ff.flags == 3'h0)
    else $error("Resume did not clear flags.");
  AST_RESUME_EN: assert property (
    resume_end && state_ff.opts[1] |=> state_ff.en == 4'h0)
    else $error("Resume did not clear enables.");
  AST_NO_ENTER_WAKE: assert property (
    i_suspend_entering |=> !o_wake_req)
    else $error("Wake issued while entering suspend.");
  AST_WAKING_HOLD: assert property (
    o_waking && !wr_src |=> $stable(state_ff.src))
    else $error("Wake source changed while waking.");
  AST_MULTI_LATCH: assert property (
    o_wake_req |-> (state_ff.src & $past(hit_en)) == $past(hit_en))
    else $error("Not every matching source bit was set.");
  AST_EEE_LOW: assert property (
    !i_energy_efficient_enable |-> src_view[14:13] == 2'h0)
    else $error("Idle wake bits visible without EEE enable.");
  AST_ONLY_ENABLED: assert property (
    o_wake_req |-> $past(frame_wake || (|hit_en)) && o_waking)
    else $error("Wake issued without an enabled cause.");
  AST_READ_ANSWER: assert property (
    i_arvalid && o_arready |=> o_rvalid)
    else $error("Read not answered in one cycle.");
  // Source bits never drop by themselves, and each cause maps to its bit.
  AST_SRC_HOLD: assert property (
    !wr_src |=> (state_ff.src & $past(state_ff.src)) == $past(state_ff.src))
    else $error("Wake source bit cleared without a software write.");
  AST_BCAST_FLAG: assert property (
    i_bcast_ok |=> state_ff.flags[0])
    else $error("Broadcast flag not set.");
  AST_PIN_LATCH: assert property (
    o_wake_req |-> (state_ff.src[wecs_pkg::SRC_PIN_LSB +: 8]
    & $past(i_pin_wake)) == $past(i_pin_wake))
    else $error("Pin wake cause not recorded.");
  AST_TX_GATED: assert property (
    !state_ff.opts[wecs_pkg::OPT_LPI_TX_EN]
    && !state_ff.src[wecs_pkg::SRC_LPI_TX]
    |=> !state_ff.src[wecs_pkg::SRC_LPI_TX])
    else $error("Transmit idle wake bit set while its enable is off.");
  AST_WAKE_PULSE: assert property (
    o_wake_req |=> !o_wake_req)
    else $error("Wake request longer than one cycle.");
  AST_STATION_WAKE: assert property (
    state_ff.st == wecs_pkg::WECS_ARMED && i_suspend_state
    && !i_suspend_entering && i_station_addr_ok
    && state_ff.en[wecs_pkg::WCS_STA_EN] |=> o_wake_req)
    else $error("Station address match did not wake.");

  COV_WAKE: cover property (o_wake_req);
  COV_MULTI: cover property (o_wake_req && $countones(state_ff.src) > 1);
  COV_RESUME: cover property (resume_end && state_ff.opts[1]);
  COV_SET_CLEAR: cover property (wr_ctrl && wr_bits[6] && i_wake_frame_ok);

endmodule : wecs_top
`default_nettype wire

// ### verilog/wecs_pkg.sv
// Constants shared by the wake event control and status block.
`default_nettype none
package wecs_pkg;
  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [11:0] WAKE_CTRL_ADDR  = 12'h140;
  localparam logic [11:0] WAKE_SRC_ADDR   = 12'h144;
  localparam logic [11:0] WAKE_OPTS_ADDR  = 12'h148;
  localparam int          ADDR_W          = 12;

  // Bit positions in the wakeup control and status register.
  localparam int WCS_FRAME_FLAG = 6;
  localparam int WCS_MAGIC_FLAG = 5;
  localparam int WCS_BCAST_FLAG = 4;
  localparam int WCS_STA_EN     = 3;
  localparam int WCS_PAT_EN     = 2;
  localparam int WCS_MAGIC_EN   = 1;
  localparam int WCS_BCAST_WAKE_EN   = 0;

  // Bit positions in the option register.
  localparam int OPT_RES_CLR_STS = 0;
  localparam int OPT_RES_CLR_EN  = 1;
  localparam int OPT_LPI_TX_EN   = 2;
  localparam int OPT_LPI_RX_EN   = 3;

  // Bit positions in the wake source register.
  localparam int SRC_PIN_LSB = 20;
  localparam int SRC_V6_SYN  = 16;
  localparam int SRC_V4_SYN  = 15;
  localparam int SRC_LPI_TX  = 14;
  localparam int SRC_LPI_RX  = 13;
  localparam logic [31:0] SRC_MASK = 32'h0FF1_E000;

  // Values after reset.
  localparam logic [2:0]  FLAGS_RST = 3'h0;
  localparam logic [3:0]  EN_RST    = 4'h0;
  localparam logic [3:0]  OPTS_RST  = 4'h0;
  localparam logic [31:0] SRC_RST   = 32'h0000_0000;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power sequencing states.
  typedef enum logic [1:0] {
    WECS_RUN,
    WECS_ARMED,
    WECS_WAKING
  } wecs_state_t;
endpackage : wecs_pkg
`default_nettype wire

// ### verif/wecs_mac_model.sv
// Behavioural receive path model that reports wake events to the block.
`timescale 1ns/1ps
`default_nettype none
module wecs_mac_model (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [15:0] i_cmd,
  output logic      [15:0] o_evt
);
  // Each command bit becomes a one-cycle event one edge later.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_evt <= 16'h0000;
    end else begin
      o_evt <= i_cmd;
    end
  end
endmodule : wecs_mac_model
`default_nettype wire

// ### verif/wake_event_control_status_bench.sv
// Self-checking bench for the wake event control and status block.
`timescale 1ns/1ps
`default_nettype none
module wake_event_control_status_bench;
  localparam logic [11:0] A_CTL = wecs_pkg::WAKE_CTRL_ADDR;
  localparam logic [11:0] A_SRC = wecs_pkg::WAKE_SRC_ADDR;
  localparam logic [11:0] A_OPT = wecs_pkg::WAKE_OPTS_ADDR;
  localparam logic [1:0]  OK    = wecs_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR   = wecs_pkg::RESP_SLVERR;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        eee, susp, entering, resume;
  logic        awready, wready, bvalid, arready, rvalid, wake_req, waking;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] cmd, evt;
  logic [3:0]  strb;
  logic [7:0]  n_wake, w0;
  logic [3:0]  en_tab [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
  logic [15:0] cm_tab [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008};
  int          n_fail, checked, cyc;

  wecs_mac_model MAC (.i_mclk(clk), .i_rst(rst), .i_cmd(cmd), .o_evt(evt));

  wecs_top #(.PIN_COUNT(8)) DUT (
    .i_mclk(clk), .i_rst(rst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(strb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp),
    .i_wake_frame_ok(evt[0]), .i_magic_ok(evt[1]), .i_bcast_ok(evt[2]),
    .i_station_addr_ok(evt[3]), .i_v6_syn_ok(evt[4]),
    .i_v4_syn_ok(evt[5]), .i_lpi_tx_exit(evt[6]),
    .i_lpi_rx_exit(evt[7]), .i_pin_wake(evt[15:8]),
    .i_energy_efficient_enable(eee), .i_suspend_state(susp),
    .i_suspend_entering(entering), .i_resume_done(resume),
    .o_wake_req(wake_req), .o_waking(waking)
  );

  // Free-running clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts wake requests so that single-cycle pulses are never missed.
  always @(posedge clk) begin
    if (rst) n_wake <= 8'h00;
    else if (wake_req === 1'b1) n_wake <= n_wake + 8'h01;
  end

  // Hang guard, far above the length of the whole sequence.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; each drops once it is taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Bready stays high after the answer, so that two writes in a row never
    // drive it twice in one time step.
    do @(posedge clk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
                    input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk(rdata, ex);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // One command cycle, then time for the model and the block to react.
  task automatic ev(input logic [15:0] c);
    cmd <= c;
    @(posedge clk);
    cmd <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask : ev

  task automatic arm;
    susp <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : arm

  task automatic wake_end;
    susp <= 1'b0;
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    @(posedge clk);
  endtask : wake_end

  task automatic give_verdict;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Main sequence; the enable table proves each enable gates its own cause.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {eee, susp, entering, resume} = 4'h0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    cmd = 16'h0;
    strb = 4'hF;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(A_CTL, 32'h0, OK);
    rd(A_SRC, 32'h0, OK);
    rd(A_OPT, 32'h0, OK);
    rd(12'h14C, 32'h0, ERR);
    wr(12'h14C, 32'hFFFF_FFFF, ERR);
    wr(A_SRC, 32'hFFFF_FFFF, OK);
    rd(A_SRC, 32'h0, OK);
    wr(A_CTL, 32'hFFFF_FFFF, OK);
    rd(A_CTL, 32'h0F, OK);
    ev(16'h0007);
    rd(A_CTL, 32'h7F, OK);
    wr(A_CTL, 32'h2F, OK);
    rd(A_CTL, 32'h5F, OK);
    wr(A_CTL, 32'h50, OK);
    rd(A_CTL, 32'h00, OK);
    wr(A_OPT, 32'h3, OK);
    // With no byte lane strobed a write must leave the register alone.
    strb <= 4'h0;
    wr(A_OPT, 32'hC, OK);
    strb <= 4'hF;
    rd(A_OPT, 32'h3, OK);
    for (int i = 0; i < 4; i++) begin
      w0 = n_wake;
      arm();
      wr(A_CTL, {28'h0, ~en_tab[i]}, OK);
      ev(cm_tab[i]);
      chk({24'h0, n_wake}, {24'h0, w0});
      wr(A_CTL, {28'h0, en_tab[i]}, OK);
      ev(cm_tab[i]);
      chk({24'h0, n_wake}, {24'h0, w0 + 8'h01});
      chk({31'h0, waking}, 32'h1);
      wake_end();
      chk({31'h0, waking}, 32'h0);
      rd(A_CTL, 32'h0, OK);
    end
    rd(A_SRC, 32'h0, OK);
    // Events during suspend entry, then a packet matching several causes.
    w0 = n_wake;
    wr(A_CTL, 32'h2, OK);
    arm();
    entering <= 1'b1;
    ev(16'h0022);
    rd(A_SRC, 32'h0, OK);
    chk({24'h0, n_wake}, {24'h0, w0});
    entering <= 1'b0;
    ev(16'h0832);
    chk({24'h0, n_wake}, {24'h0, w0 + 8'h01});
    rd(A_SRC, 32'h0081_8000, OK);
    ev(16'h0414);
    rd(A_SRC, 32'h0081_8000, OK);
    wake_end();
    rd(A_SRC, 32'h0081_8000, OK);
    wr(A_SRC, 32'h0080_8000, OK);
    rd(A_SRC, 32'h0001_0000, OK);
    // Idle exit causes; the transmit enable is off in the first round.
    wr(A_SRC, 32'hFFFF_FFFF, OK);
    wr(A_OPT, 32'h8, OK);
    eee <= 1'b1;
    arm();
    ev(16'h0040);
    rd(A_SRC, 32'h0, OK);
    ev(16'h0080);
    rd(A_SRC, 32'h2000, OK);
    wake_end();
    wr(A_SRC, 32'h2000, OK);
    wr(A_OPT, 32'h4, OK);
    arm();
    ev(16'h0080);
    rd(A_SRC, 32'h0, OK);
    ev(16'h0040);
    rd(A_SRC, 32'h4000, OK);
    eee <= 1'b0;
    rd(A_SRC, 32'h0, OK);
    eee <= 1'b1;
    rd(A_SRC, 32'h4000, OK);
    wake_end();
    give_verdict();
  end
endmodule : wake_event_control_status_bench
`default_nettype wire
